// ---- include/sfcfe_defs.svh ----
/*
 * Constants of the serial flash command front end: opcodes, field widths,
 * counts and reset values.
 * Assumes inclusion by its bare name; definitions only.
 */
`ifndef SFCFE_DEFS_SVH
`define SFCFE_DEFS_SVH

// Opcodes, as shifted in MSB first
`define SFCFE_OP_READ_FAST   8'h0b
`define SFCFE_OP_READ_SLOW   8'h03
`define SFCFE_OP_ERASE_4K    8'h20
`define SFCFE_OP_ERASE_32K   8'h52
`define SFCFE_OP_ERASE_64K   8'hd8
`define SFCFE_OP_CHIP_ERASE1 8'h60
`define SFCFE_OP_CHIP_ERASE2 8'hc7
`define SFCFE_OP_PROGRAM     8'h02
`define SFCFE_OP_WRITE_EN    8'h06
`define SFCFE_OP_WRITE_DIS   8'h04
`define SFCFE_OP_PROTECT     8'h36
`define SFCFE_OP_UNPROTECT   8'h39
`define SFCFE_OP_READ_PROT   8'h3c
`define SFCFE_OP_READ_STATUS 8'h05
`define SFCFE_OP_WRITE_STAT  8'h01
`define SFCFE_OP_READ_ID     8'h9f
`define SFCFE_OP_POWER_DOWN  8'hb9
`define SFCFE_OP_RESUME      8'hab

// Field widths and counts
`define SFCFE_ADDR_W         21
`define SFCFE_ADDR_LAST_BYTE 2'h2
`define SFCFE_BIT_LAST       3'h7
`define SFCFE_PAGE_OFF_W     8

// Reset values
`define SFCFE_RST_BYTE       8'h00
`define SFCFE_RST_ADDR       24'h000000
`define SFCFE_RST_BITS       3'h0
`define SFCFE_RST_BYTES      2'h0

`endif

// ---- include/sfcfe_pkg.sv ----
/*
 * Types of the serial flash command front end: decoded commands and the
 * framing state machine.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sfcfe_pkg;

    // Decoded command kinds handed to the operation units
    typedef enum logic [4:0] {
        CMD_NONE,
        CMD_READ_FAST,
        CMD_READ_SLOW,
        CMD_ERASE_4K,
        CMD_ERASE_32K,
        CMD_ERASE_64K,
        CMD_CHIP_ERASE,
        CMD_PROGRAM,
        CMD_WRITE_EN,
        CMD_WRITE_DIS,
        CMD_PROTECT,
        CMD_UNPROTECT,
        CMD_READ_PROT,
        CMD_READ_STATUS,
        CMD_WRITE_STATUS,
        CMD_READ_ID,
        CMD_POWER_DOWN,
        CMD_RESUME
    } sfcfe_cmd_e;

    // Framing states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA_IN,
        ST_DATA_OUT,
        ST_ARMED,
        ST_IGNORE
    } sfcfe_state_e;

endpackage : sfcfe_pkg

`default_nettype wire

// ---- hdl/sfcfe_sync.sv ----
/*
 * Two-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level relative to core_clk; no bus coherence.
 */
`timescale 1ns/1ps
`default_nettype none

module sfcfe_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1; // Idle level of chip select
            sync_out <= '1; // No false select edge after reset
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : sfcfe_sync

`default_nettype wire

// ---- hdl/sfcfe_core.sv ----
/*
 * SPI-slave command front end of a serial flash: frames operations by chip
 * select, shifts opcode, address, dummy and data bytes, decodes the opcode
 * table and hands requests to the internal operation units.
 * Assumes SCK, chip select and SI are asynchronous pins oversampled by
 * core_clk (SCK well below a quarter of core_clk), and that the read units
 * present rd_data the cycle after rd_byte_req.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_defs.svh"

module sfcfe_core
    import sfcfe_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // Serial pins
    input  wire logic                     spi_sck,
    input  wire logic                     spi_cs_n,
    input  wire logic                     spi_si,
    output logic                          spi_so,
    output logic                          spi_so_oe,
    // Status unit
    input  wire logic                     write_latch_flag,
    // Command requests
    output logic                          cmd_valid,
    output sfcfe_cmd_e                    cmd_kind,
    output logic [`SFCFE_ADDR_W-1:0]      cmd_addr,
    output logic [7:0]                    cmd_data,
    output logic                          cmd_abort,
    // Read data path
    output logic                          rd_byte_req,
    input  wire logic [7:0]               rd_data,
    // Program data path
    output logic                          wr_valid,
    output logic [`SFCFE_ADDR_W-1:0]      wr_addr,
    output logic [7:0]                    wr_data
);

    logic                          sck_s;
    logic                          cs_n_s;
    logic                          si_s;
    logic                          sck_d_reg;
    logic                          cs_n_d_reg;
    logic                          sck_rise;
    logic                          sck_fall;
    logic                          cs_start;
    logic                          cs_end;
    sfcfe_state_e                  state_reg;
    sfcfe_state_e                  state_next;
    sfcfe_cmd_e                    kind_reg;
    sfcfe_cmd_e                    op_kind;
    logic [2:0]                    bit_cnt_reg;
    logic [1:0]                    byte_cnt_reg;
    logic [7:0]                    shift_reg;
    logic [7:0]                    rx_byte;
    logic                          byte_done;
    logic [23:0]                   addr_reg;
    logic [`SFCFE_PAGE_OFF_W-1:0]  page_off_reg;
    logic                          got_data_reg;
    logic [7:0]                    data_reg;
    logic [7:0]                    out_shift_reg;
    logic                          load_pend_reg;
    logic                          modify;
    logic                          complete;
    logic                          fire_end;
    logic                          fire_read;

    // All three pins cross into core_clk
    sfcfe_sync #(
        .WIDTH (3)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .async_in ({spi_sck, spi_cs_n, spi_si}),
        .sync_out ({sck_s, cs_n_s, si_s})
    );

    // Edge history of the synchronised levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_d_reg  <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else if (ce) begin
            sck_d_reg  <= sck_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    // Modes 0 and 3 look the same here: only edges inside a frame count
    assign sck_rise  = sck_s & ~sck_d_reg & ~cs_n_s;
    assign sck_fall  = ~sck_s & sck_d_reg & ~cs_n_s;
    assign cs_start  = ~cs_n_s & cs_n_d_reg;
    assign cs_end    = cs_n_s & ~cs_n_d_reg;
    assign rx_byte   = {shift_reg[6:0], si_s};
    assign byte_done = sck_rise && (bit_cnt_reg == `SFCFE_BIT_LAST);

    // Opcode table
    always_comb begin
        case (rx_byte)
            `SFCFE_OP_READ_FAST:   op_kind = CMD_READ_FAST;
            `SFCFE_OP_READ_SLOW:   op_kind = CMD_READ_SLOW;
            `SFCFE_OP_ERASE_4K:    op_kind = CMD_ERASE_4K;
            `SFCFE_OP_ERASE_32K:   op_kind = CMD_ERASE_32K;
            `SFCFE_OP_ERASE_64K:   op_kind = CMD_ERASE_64K;
            `SFCFE_OP_CHIP_ERASE1: op_kind = CMD_CHIP_ERASE;
            `SFCFE_OP_CHIP_ERASE2: op_kind = CMD_CHIP_ERASE;
            `SFCFE_OP_PROGRAM:     op_kind = CMD_PROGRAM;
            `SFCFE_OP_WRITE_EN:    op_kind = CMD_WRITE_EN;
            `SFCFE_OP_WRITE_DIS:   op_kind = CMD_WRITE_DIS;
            `SFCFE_OP_PROTECT:     op_kind = CMD_PROTECT;
            `SFCFE_OP_UNPROTECT:   op_kind = CMD_UNPROTECT;
            `SFCFE_OP_READ_PROT:   op_kind = CMD_READ_PROT;
            `SFCFE_OP_READ_STATUS: op_kind = CMD_READ_STATUS;
            `SFCFE_OP_WRITE_STAT:  op_kind = CMD_WRITE_STATUS;
            `SFCFE_OP_READ_ID:     op_kind = CMD_READ_ID;
            `SFCFE_OP_POWER_DOWN:  op_kind = CMD_POWER_DOWN;
            `SFCFE_OP_RESUME:      op_kind = CMD_RESUME;
            default:               op_kind = CMD_NONE;
        endcase
    end

    // Framing state machine, advanced on whole bytes
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                state_next = ST_IDLE;
            end
            ST_OPCODE: begin
                if (byte_done) begin
                    case (op_kind)
                        CMD_NONE:         state_next = ST_IGNORE;
                        CMD_READ_FAST,
                        CMD_READ_SLOW,
                        CMD_ERASE_4K,
                        CMD_ERASE_32K,
                        CMD_ERASE_64K,
                        CMD_PROGRAM,
                        CMD_PROTECT,
                        CMD_UNPROTECT,
                        CMD_READ_PROT:    state_next = ST_ADDR;
                        CMD_READ_STATUS,
                        CMD_READ_ID:      state_next = ST_DATA_OUT;
                        CMD_WRITE_STATUS: state_next = ST_DATA_IN;
                        default:          state_next = ST_ARMED;
                    endcase
                end
            end
            ST_ADDR: begin
                if (byte_done && byte_cnt_reg == `SFCFE_ADDR_LAST_BYTE) begin
                    case (kind_reg)
                        CMD_READ_FAST: state_next = ST_DUMMY;
                        CMD_READ_SLOW,
                        CMD_READ_PROT: state_next = ST_DATA_OUT;
                        CMD_PROGRAM:   state_next = ST_DATA_IN;
                        default:       state_next = ST_ARMED;
                    endcase
                end
            end
            ST_DUMMY: begin
                if (byte_done) begin
                    state_next = ST_DATA_OUT;
                end
            end
            ST_DATA_IN: begin
                // Status write takes one byte; later bytes fall on deaf ears
                if (byte_done && kind_reg == CMD_WRITE_STATUS) begin
                    state_next = ST_ARMED;
                end
            end
            ST_DATA_OUT: begin
                state_next = ST_DATA_OUT;
            end
            ST_ARMED: begin
                state_next = ST_ARMED;
            end
            ST_IGNORE: begin
                state_next = ST_IGNORE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (cs_start) begin
            state_next = ST_OPCODE;
        end
        if (cs_end) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Bit and byte counters restart with every selection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg  <= `SFCFE_RST_BITS;
            byte_cnt_reg <= `SFCFE_RST_BYTES;
            shift_reg    <= `SFCFE_RST_BYTE;
        end else if (ce) begin
            if (cs_start) begin
                bit_cnt_reg  <= `SFCFE_RST_BITS;
                byte_cnt_reg <= `SFCFE_RST_BYTES;
            end else if (sck_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg   <= rx_byte;
                if (byte_done && state_reg == ST_ADDR) begin
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                end
            end
        end
    end

    // Command kind, address and received data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_reg     <= CMD_NONE;
            addr_reg     <= `SFCFE_RST_ADDR;
            page_off_reg <= `SFCFE_RST_BYTE;
            got_data_reg <= 1'b0;
            data_reg     <= `SFCFE_RST_BYTE;
        end else if (ce) begin
            if (cs_start) begin
                kind_reg     <= CMD_NONE;
                got_data_reg <= 1'b0;
            end else if (byte_done) begin
                case (state_reg)
                    ST_OPCODE: begin
                        kind_reg <= op_kind;
                    end
                    ST_ADDR: begin
                        addr_reg     <= {addr_reg[15:0], rx_byte};
                        page_off_reg <= rx_byte;
                    end
                    ST_DATA_IN: begin
                        data_reg     <= rx_byte;
                        got_data_reg <= 1'b1;
                        // Overflow stays within the page
                        if (got_data_reg) begin
                            page_off_reg <= page_off_reg + 8'h01;
                        end
                    end
                    default: begin
                        kind_reg <= kind_reg;
                    end
                endcase
            end
        end
    end

    // Completion checks at release
    assign modify    = (kind_reg == CMD_PROGRAM) || (kind_reg == CMD_ERASE_4K) ||
                       (kind_reg == CMD_ERASE_32K) || (kind_reg == CMD_ERASE_64K) ||
                       (kind_reg == CMD_CHIP_ERASE);
    // A trailing partial program byte spoils the whole program
    assign complete  = (state_reg == ST_ARMED) ||
                       (state_reg == ST_DATA_IN && got_data_reg &&
                        bit_cnt_reg == `SFCFE_RST_BITS);
    assign fire_end  = cs_end && complete && (!modify || write_latch_flag);
    assign fire_read = byte_done && state_next == ST_DATA_OUT && state_reg != ST_DATA_OUT;

    // Request pulses to the operation units
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid   <= 1'b0;
            cmd_abort   <= 1'b0;
            cmd_kind    <= CMD_NONE;
            cmd_addr    <= '0;
            cmd_data    <= `SFCFE_RST_BYTE;
            rd_byte_req <= 1'b0;
            wr_valid    <= 1'b0;
            wr_addr     <= '0;
            wr_data     <= `SFCFE_RST_BYTE;
        end else if (ce) begin
            cmd_valid   <= fire_end || fire_read;
            // Lets the status unit drop the latch flag on a broken modify
            cmd_abort   <= cs_end && modify && !complete && state_reg != ST_IDLE;
            rd_byte_req <= fire_read || (byte_done && state_reg == ST_DATA_OUT);
            wr_valid    <= byte_done && state_reg == ST_DATA_IN && kind_reg == CMD_PROGRAM;
            if (fire_read) begin
                cmd_kind <= kind_reg == CMD_NONE ? op_kind : kind_reg;
                cmd_addr <= state_reg == ST_DUMMY ? addr_reg[`SFCFE_ADDR_W-1:0]
                                                  : {addr_reg[`SFCFE_ADDR_W-9:0], rx_byte};
            end else if (fire_end) begin
                cmd_kind <= kind_reg;
                cmd_addr <= addr_reg[`SFCFE_ADDR_W-1:0];
                cmd_data <= data_reg;
            end
            if (byte_done && state_reg == ST_DATA_IN) begin
                wr_data <= rx_byte;
                wr_addr <= {addr_reg[`SFCFE_ADDR_W-1:8],
                            got_data_reg ? page_off_reg + 8'h01 : page_off_reg};
            end
        end
    end

    // Output shifter: load a byte, launch bits on falling SCK
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_reg <= 1'b0;
            out_shift_reg <= `SFCFE_RST_BYTE;
            spi_so        <= 1'b0;
            spi_so_oe     <= 1'b0;
        end else if (ce) begin
            load_pend_reg <= rd_byte_req;
            if (cs_end || cs_start) begin
                spi_so_oe <= 1'b0;
            end else if (load_pend_reg) begin
                // Load lands long before the next falling edge
                out_shift_reg <= rd_data;
            end else if (sck_fall && state_reg == ST_DATA_OUT) begin
                spi_so        <= out_shift_reg[7];
                spi_so_oe     <= 1'b1;
                out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            end
        end
    end

endmodule : sfcfe_core

`default_nettype wire

// ---- dv/sfcfe_core_asserts.sv ----
/*
 * Port checker of the serial flash command front end.
 * Assumes it is bound to sfcfe_core and SCK half periods of 8 core cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module sfcfe_core_asserts
    import sfcfe_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Serial pins
    input wire logic        spi_sck,
    input wire logic        spi_cs_n,
    input wire logic        spi_so,
    input wire logic        spi_so_oe,
    // Requests
    input wire logic        write_latch_flag,
    input wire logic        cmd_valid,
    input wire sfcfe_cmd_e  cmd_kind,
    input wire logic [20:0] cmd_addr,
    input wire logic        cmd_abort,
    input wire logic        rd_byte_req,
    input wire logic        wr_valid,
    input wire logic [20:0] wr_addr
);
    logic [20:0] last_wr_reg;
    logic        wr_seen_reg;

    // Last program address of this frame, forgotten at release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_wr_reg <= 21'h000000;
            wr_seen_reg <= 1'b0;
        end else if (spi_cs_n) begin
            wr_seen_reg <= 1'b0;
        end else if (wr_valid) begin
            last_wr_reg <= wr_addr;
            wr_seen_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // SO may only move about three cycles after a fall, never soon after a rise
    sequence sck_rise_sel;
        $rose(spi_sck) && !spi_cs_n;
    endsequence
    sequence so_holds;
        $stable(spi_so)[*6];
    endsequence

    chk_so_after_rise: assert property (sck_rise_sel |=> so_holds)
        else $error("SO moved right after an SCK rise");
    chk_cmd_one_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command request longer than one cycle");
    chk_abort_alone: assert property (cmd_abort |=> !cmd_abort && !cmd_valid)
        else $error("abort followed by a request");
    chk_oe_release: assert property ($rose(spi_cs_n) |-> ##[1:6] !spi_so_oe)
        else $error("SO still driven after release");
    chk_oe_idle: assert property (spi_cs_n [*8] |-> !spi_so_oe)
        else $error("SO driven while deselected");
    chk_latch_gate: assert property (cmd_valid && (cmd_kind inside {CMD_PROGRAM, CMD_ERASE_4K, CMD_ERASE_32K,
        CMD_ERASE_64K, CMD_CHIP_ERASE}) |-> write_latch_flag)
        else $error("modify request without write latch flag");
    chk_read_fetch: assert property (cmd_valid && (cmd_kind inside {CMD_READ_STATUS, CMD_READ_ID})
        |-> ##[0:2] rd_byte_req)
        else $error("read started without a byte fetch");
    chk_kind_hold: assert property (!cmd_valid |-> $stable(cmd_kind) && $stable(cmd_addr))
        else $error("request fields moved without a request");
    chk_page_wrap: assert property (wr_valid && wr_seen_reg
        |-> wr_addr == {last_wr_reg[20:8], last_wr_reg[7:0] + 8'h01})
        else $error("program address left its page");
endmodule : sfcfe_core_asserts

bind sfcfe_core sfcfe_core_asserts u_chk (.core_clk, .rst_n, .spi_sck, .spi_cs_n, .spi_so, .spi_so_oe,
    .write_latch_flag, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_abort, .rd_byte_req, .wr_valid, .wr_addr);

`default_nettype wire

// ---- dv/sfcfe_spi_master.sv ----
/*
 * SPI master model facing the command front end, modes 0 and 3.
 * Assumes a 200 MHz core_clk; SCK period is 16 core cycles (80 ns).
 */
`timescale 1ns/1ps
`default_nettype none

module sfcfe_spi_master (
    // Clock
    input  wire logic core_clk,
    // Serial pins
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so
);
    logic mode3;

    // Idle pins at time zero
    initial begin
        mode3 = 1'b0;
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end

    // Pins move just after a core edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // Clock parked at its idle level before select falls
    task automatic start();
        spi_sck = mode3;
        step(8);
        spi_cs_n = 1'b0;
        step(8);
    endtask : start

    // Launch on the fall, capture SO on the rise
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            spi_sck = 1'b0;
            spi_si = tx[i];
            step(8);
            spi_sck = 1'b1;
            rx[i] = spi_so;
            step(8);
        end
    endtask : xfer

    // Clock back to idle, then release; SI shows no stale level
    task automatic stop();
        spi_sck = mode3;
        step(8);
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        step(8);
    endtask : stop
endmodule : sfcfe_spi_master

`default_nettype wire

// ---- dv/sfcfe_core_tb.sv ----
/*
 * Self-checking bench of the command front end: opcode table, wrap, refusals.
 * Assumes sfcfe_core, its checker bind and the SPI master model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_defs.svh"

module sfcfe_core_tb
    import sfcfe_pkg::*;
();
    logic                     core_clk, rst_n, ce, write_latch_flag;
    logic                     spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
    logic                     cmd_valid, cmd_abort, rd_byte_req, wr_valid;
    logic [7:0]               rd_data, cmd_data, wr_data, rd_next;
    logic [`SFCFE_ADDR_W-1:0] cmd_addr, wr_addr;
    sfcfe_cmd_e               cmd_kind;
    int                       errors, cmp_count, aborts;
    sfcfe_cmd_e               kq[$];
    logic [20:0]              aq[$], wq[$];
    logic [7:0]               dq[$], wdq[$], rdq[$], wexp[$];
    logic [7:0]               ops[18] = '{8'h0b, 8'h03, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h02, 8'h06,
                                          8'h04, 8'h36, 8'h39, 8'h3c, 8'h05, 8'h01, 8'h9f, 8'hb9, 8'hab};
    sfcfe_cmd_e               kinds[18] = '{CMD_READ_FAST, CMD_READ_SLOW, CMD_ERASE_4K, CMD_ERASE_32K,
        CMD_ERASE_64K, CMD_CHIP_ERASE, CMD_CHIP_ERASE, CMD_PROGRAM, CMD_WRITE_EN, CMD_WRITE_DIS, CMD_PROTECT,
        CMD_UNPROTECT, CMD_READ_PROT, CMD_READ_STATUS, CMD_WRITE_STATUS, CMD_READ_ID, CMD_POWER_DOWN, CMD_RESUME};

    sfcfe_core dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .write_latch_flag(write_latch_flag),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_abort(cmd_abort), .rd_byte_req(rd_byte_req), .rd_data(rd_data), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data));
    sfcfe_spi_master m (.core_clk(core_clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_so(spi_so_oe ? spi_so : ~spi_so)); // Undriven SO reads back inverted

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Record requests; serve a random byte the cycle after each fetch
    always @(posedge core_clk) begin
        if (cmd_valid === 1'b1) begin
            kq.push_back(cmd_kind);
            aq.push_back(cmd_addr);
            dq.push_back(cmd_data);
        end
        if (wr_valid === 1'b1) begin
            wq.push_back(wr_addr);
            wdq.push_back(wr_data);
        end
        if (cmd_abort === 1'b1) aborts++;
        if (rd_byte_req === 1'b1) begin
            rd_data <= rd_next;
            rdq.push_back(rd_next);
            rd_next = 8'($urandom);
        end
    end

    // Address bytes each opcode needs
    function automatic int naddr(input logic [7:0] op);
        return (op inside {8'h0b, 8'h03, 8'h20, 8'h52, 8'hd8, 8'h02, 8'h36, 8'h39, 8'h3c}) ? 3 : 0;
    endfunction : naddr
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : expect_eq

    task automatic clear_q();
        kq = {};
        aq = {};
        dq = {};
        wq = {};
        wdq = {};
        rdq = {};
        wexp = {};
        aborts = 0;
    endtask : clear_q

    // One frame in a random mode: opcode, address, dummy, data in, partial tail, bytes read
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nadr, input int nin,
                         input int nrd, input int tail);
        logic [7:0] rx;
        logic [7:0] got[$];
        clear_q();
        m.mode3 = 1'($urandom);
        m.start();
        m.xfer(op, 8, rx);
        for (int i = 0; i < nadr; i++) m.xfer(8'(a >> (16 - 8 * i)), 8, rx);
        if (op == 8'h0b) m.xfer(8'($urandom), 8, rx);
        for (int i = 0; i < nin; i++) begin
            wexp.push_back(8'($urandom));
            m.xfer(wexp[i], 8, rx);
        end
        if (tail > 0) m.xfer(8'($urandom), tail, rx);
        for (int i = 0; i < nrd; i++) begin
            m.xfer(8'($urandom), 8, rx);
            got.push_back(rx);
        end
        m.stop();
        m.step(20);
        foreach (got[i]) expect_eq(got[i], rdq[i], "read byte");
    endtask : frame

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        $display("mismatch at %0t: run did not finish", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [23:0] a;
        logic [7:0]  op;
        logic [7:0]  rx;
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        write_latch_flag = 1'b1;
        rd_data = 8'h00;
        void'($urandom(32'h5a63596b));
        rd_next = 8'($urandom);
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        m.step(4);
        // Whole opcode table, random addresses with random top bits
        foreach (ops[i]) begin
            a = 24'($urandom);
            frame(ops[i], a, naddr(ops[i]), int'(ops[i] inside {8'h02, 8'h01}),
                  (ops[i] inside {8'h0b, 8'h03, 8'h3c, 8'h05, 8'h9f}) ? 2 : 0, 0);
            expect_eq(kq.size(), 1, "request count");
            expect_eq(kq[0], kinds[i], "request kind");
            if (naddr(ops[i]) == 3) expect_eq(aq[0], a[20:0], "request address");
            if (ops[i] == 8'h01) expect_eq(dq[0], wexp[0], "status byte");
        end
        // Program over the page end wraps back inside the page
        a = {8'($urandom), 8'($urandom), 8'hfe};
        frame(8'h02, a, 3, 3, 0, 0);
        for (int i = 0; i < 3; i++) begin
            expect_eq(wq[i], {a[20:8], 8'(8'hfe + i)}, "wrap address");
            expect_eq(wdq[i], wexp[i], "program byte");
        end
        expect_eq(aq[0], a[20:0], "program start");
        // Unknown opcodes, operands that look like write enable
        for (int i = 0; i < 6; i++) begin
            op = 8'($urandom);
            if (op inside {ops}) continue;
            frame(op, 24'h060606, 3, 0, 0, 0);
            expect_eq(kq.size(), 0, "unknown opcode request");
        end
        // Short address, partial program byte: nothing done; abort checked on the short address only
        frame(8'h20, 24'($urandom), 2, 0, 0, 0);
        expect_eq(kq.size(), 0, "short address request");
        expect_eq(aborts > 0, 1, "short address abort");
        frame(8'h02, 24'($urandom), 3, 1, 0, 5);
        expect_eq(kq.size(), 0, "partial byte request");
        // Half an opcode, then a clean frame counts afresh
        clear_q();
        m.start();
        m.xfer(8'h06, 4, rx);
        m.stop();
        m.step(20);
        expect_eq(kq.size(), 0, "half opcode request");
        frame(8'h06, 24'h000000, 0, 0, 0, 0);
        expect_eq(kq[0], CMD_WRITE_EN, "fresh opcode");
        // Without the write latch flag, program and chip erase are dropped
        write_latch_flag = 1'b0;
        frame(8'h02, 24'($urandom), 3, 1, 0, 0);
        expect_eq(kq.size(), 0, "unlatched program");
        frame(8'hc7, 24'h000000, 0, 0, 0, 0);
        expect_eq(kq.size(), 0, "unlatched chip erase");
        write_latch_flag = 1'b1;
        report_and_stop();
    end
endmodule : sfcfe_core_tb

`default_nettype wire
